/* File: rtl/alarm_pkg.sv */
// Shared constants, register map and types for the dual alarm logic.
// Assumes a single 250 MHz system clock.
package alarm_pkg;
  localparam int NUM_CH = 2;
  localparam int DISP_W = 18;
  localparam int TIME_W = 12;
  localparam int CODE_W = 16;
  localparam int ADDR_W = 6;
  localparam int CTRL_W = 8;
  localparam logic [TIME_W-1:0] TIME_MAX = 12'he10;
  localparam int TICK_PERIOD_MS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_SETPOINT0 = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_SETPOINT1 = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_HYST0 = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_HYST1 = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_DELAY0 = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_DELAY1 = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_SILENCE0 = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_SILENCE1 = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_ACCESS_CODE = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_SPAN_MIN = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_SPAN_MAX = 6'h2c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h30;
  localparam logic [ADDR_W-1:0] OFS_DISPLAY = 6'h34;
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_HIGH_LSB = 2;
  localparam int CTRL_NC_LSB = 4;
  localparam int CTRL_FLASH_BIT = 6;
  localparam int CTRL_ACCESS_BIT = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [CODE_W-1:0] CODE_OPEN = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_RESET = CODE_OPEN;
  localparam logic signed [DISP_W-1:0] SPAN_MIN_RESET = -18'sd125;
  localparam logic signed [DISP_W-1:0] SPAN_MAX_RESET = 18'sd10125;
  localparam logic [DISP_W-1:0] VALUE_RESET = 18'h00000;
  localparam logic [TIME_W-1:0] TIME_RESET = 12'h000;

  typedef struct packed {
    logic en;
    logic high;
    logic signed [DISP_W-1:0] setpoint;
    logic [DISP_W-1:0] hyst;
    logic [TIME_W-1:0] delay_s;
    logic [TIME_W-1:0] silence_s;
  } chan_cfg_t;

  typedef struct packed {
    logic step;
    logic up;
    logic down;
    logic exit;
  } btn_t;

  typedef enum logic [1:0] {CH_IDLE, CH_DELAYING, CH_ACTIVE, CH_SILENCED} chan_state_t;
  typedef enum logic [1:0] {MENU_DISPLAY, MENU_CODE, MENU_SELECT, MENU_EDIT} menu_state_t;
  typedef enum logic [1:0] {SHOW_VALUE, SHOW_TAG1, SHOW_TAG2, SHOW_MENU} disp_sel_t;
endpackage : alarm_pkg

/* File: rtl/second_tick.sv */
// One-second tick generator and slow flash phase.
// Assumes CYCLES system clocks make one second.
`timescale 1ns/1ps
module second_tick import alarm_pkg::*; #(
  parameter int CYCLES = TICK_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  output logic o_tick,
  output logic o_phase
);
  localparam int CW = $clog2(CYCLES) + 1;
  logic [CW-1:0] cnt;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      cnt <= '0;
      o_tick <= 1'b0;
      o_phase <= 1'b0;
    end else if (cnt == CW'(CYCLES - 1)) begin
      cnt <= '0;
      o_tick <= 1'b1;
      o_phase <= ~o_phase;
    end else begin
      cnt <= cnt + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule : second_tick

/* File: rtl/alarm_channel.sv */
// One alarm channel: trip and release with hysteresis, delay, accept and silence.
// Assumes i_tick is a one-cycle pulse once a second and i_accept a one-cycle pulse.
`timescale 1ns/1ps
module alarm_channel import alarm_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_tick,
  input wire logic i_flash_phase,
  input wire logic i_accept,
  input wire logic signed [DISP_W-1:0] i_display,
  input wire chan_cfg_t i_cfg,
  output logic o_active,
  output logic o_annunciator,
  output chan_state_t o_state
);
  // Two guard bits: setpoint minus hysteresis can reach three times the display range
  logic signed [DISP_W+1:0] disp_x, sp_x, hyst_x;
  logic cond, cond_now, trip, release_ok;
  logic [TIME_W-1:0] cnt, cnt_inc;

  assign disp_x = (DISP_W+2)'(i_display);
  assign sp_x = (DISP_W+2)'(i_cfg.setpoint);
  assign hyst_x = $signed({2'b00, i_cfg.hyst});
  assign trip = i_cfg.high ? (disp_x >= sp_x) : (disp_x <= sp_x);
  assign release_ok = i_cfg.high ? (disp_x < sp_x - hyst_x) : (disp_x > sp_x + hyst_x);
  assign cond_now = trip || (cond && !release_ok);
  assign cnt_inc = cnt + 1'b1;
  assign o_active = (o_state == CH_ACTIVE);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      cond <= 1'b0;
    end else begin
      cond <= i_cfg.en && cond_now;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_state <= CH_IDLE;
      cnt <= '0;
    end else if (!i_cfg.en) begin
      o_state <= CH_IDLE;
      cnt <= '0;
    end else begin
      case (o_state)
        CH_IDLE: begin
          cnt <= '0;
          if (cond_now) begin
            o_state <= (i_cfg.delay_s == '0) ? CH_ACTIVE : CH_DELAYING;
          end
        end
        CH_DELAYING: begin
          if (!cond_now) begin
            o_state <= CH_IDLE;
          end else if (i_tick) begin
            cnt <= (cnt_inc >= i_cfg.delay_s) ? '0 : cnt_inc;
            if (cnt_inc >= i_cfg.delay_s) begin
              o_state <= CH_ACTIVE;
            end
          end
        end
        CH_ACTIVE: begin
          cnt <= '0;
          if (!cond_now) begin
            o_state <= CH_IDLE;
          end else if (i_accept && i_cfg.silence_s != '0) begin
            o_state <= CH_SILENCED;
          end
        end
        CH_SILENCED: begin
          if (!cond_now) begin
            o_state <= CH_IDLE;
          end else if (i_tick) begin
            cnt <= (cnt_inc >= i_cfg.silence_s) ? '0 : cnt_inc;
            if (cnt_inc >= i_cfg.silence_s) begin
              o_state <= CH_ACTIVE;
            end
          end
        end
        default: o_state <= CH_IDLE;
      endcase
    end
  end

  always_comb begin
    case (o_state)
      CH_ACTIVE: o_annunciator = 1'b1;
      CH_DELAYING: o_annunciator = i_flash_phase;
      CH_SILENCED: o_annunciator = i_flash_phase;
      default: o_annunciator = 1'b0;
    endcase
  end

  sequence s_silence_due;
    o_state == CH_SILENCED && i_tick && cnt_inc >= i_cfg.silence_s;
  endsequence

  a_disable_clears: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !i_cfg.en |=> o_state == CH_IDLE && !o_active)
    else $error("disabled channel still alarming");
  a_zero_delay: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_cfg.en && o_state == CH_IDLE && cond_now && i_cfg.delay_s == '0 |=> o_active)
    else $error("zero delay did not activate at once");
  a_delay_lapse: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_state == CH_DELAYING && !cond_now |=> o_state == CH_IDLE ##1 cnt == '0)
    else $error("delay timing not restarted on lapse");
  a_solid_active: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_active |-> o_annunciator)
    else $error("annunciator not solid with output active");
  a_accept_silence: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_cfg.en && o_active && cond_now && i_accept && i_cfg.silence_s != '0 |=> o_state == CH_SILENCED && !o_active)
    else $error("accept did not silence output");
  a_silence_end: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    s_silence_due ##0 (i_cfg.en && cond_now) |=> o_active)
    else $error("output not restored after silence");
  a_silence_flash: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_state == CH_SILENCED |-> o_annunciator == i_flash_phase)
    else $error("annunciator not flashing while silenced");
endmodule : alarm_channel

/* File: rtl/dual_process_alarm_logic.sv */
// Dual alarm logic: Avalon-MM register file, direct setpoint menu, outputs and display sequencing.
// Assumes buttons are debounced one-cycle pulses and the display value is synchronous to i_clk_sys.
// Function
// - Channel enable leaves other settings untouched.
// - Setpoints accepted only inside display span.
// - Each channel independently high or low.
// - Idle polarity selects open or closed output.
// - High alarm releases below setpoint minus hysteresis.
// - Delay 0 to 3600 s, zero immediate.
// - Flash during delay, restart on lapse.
// - Annunciator solid once output active.
// - Tag display waits for active output.
// - Silence 0 to 3600 s; nonzero enables accept.
// - Accept drops output for silence time.
// - Output returns after silence if condition persists.
// - Annunciator flashes while silenced.
// - No tag display during silence.
// - Alternate value and active tags in turn.
// - One annunciator per channel.
// - Step plus up opens setpoint menu when enabled.
// - Four-digit code; zero code grants access.
// - Reset: access off, code zero.
// - Up/down edit digit, step advances, exit stores.
// - Up/down toggles two-state choice, exit returns.
// - Compare against displayed value.
// - Trip on equality with setpoint.
`timescale 1ns/1ps
module dual_process_alarm_logic import alarm_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic signed [DISP_W-1:0] i_display_value,
  input wire btn_t i_buttons,
  output logic [NUM_CH-1:0] o_alarm_switch,
  output logic [NUM_CH-1:0] o_annunciator,
  output disp_sel_t o_display_sel,
  output logic [DISP_W-1:0] o_edit_value,
  output logic [1:0] o_edit_digit
);
  logic tick, flash_phase;
  logic [CTRL_W-1:0] ctrl;
  logic signed [DISP_W-1:0] setpoint [NUM_CH];
  logic [DISP_W-1:0] hyst [NUM_CH];
  logic [TIME_W-1:0] delay_s [NUM_CH];
  logic [TIME_W-1:0] silence_s [NUM_CH];
  logic [CODE_W-1:0] access_code;
  logic signed [DISP_W-1:0] span_min, span_max;
  chan_cfg_t cfg [NUM_CH];
  logic [NUM_CH-1:0] ch_active, ch_annun;
  chan_state_t ch_state [NUM_CH];
  menu_state_t menu;
  logic [1:0] digit;
  logic sel_ch;
  logic signed [DISP_W-1:0] edit_val;
  logic [CODE_W-1:0] code_entry;
  logic [1:0] alt_step;
  logic [31:0] rd_mux, wr_word;
  logic wr_en, accept, menu_store, wr_time_ok;
  logic signed [DISP_W-1:0] wr_value;

  function automatic logic [31:0] zx(input logic [DISP_W-1:0] v);
    return {{(32-DISP_W){1'b0}}, v};
  endfunction : zx

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [DISP_W-1:0] weight(input logic [1:0] d);
    case (d)
      2'h0: return 18'h00001;
      2'h1: return 18'h0000a;
      2'h2: return 18'h00064;
      default: return 18'h003e8;
    endcase
  endfunction : weight

  function automatic logic [3:0] bcd_step(input logic [3:0] n, input logic up);
    if (up) begin
      return (n >= 4'h9) ? 4'h0 : n + 4'h1;
    end
    return (n == 4'h0 || n > 4'h9) ? 4'h9 : n - 4'h1;
  endfunction : bcd_step

  function automatic logic in_span(input logic signed [DISP_W-1:0] v, input logic signed [DISP_W-1:0] lo,
                                   input logic signed [DISP_W-1:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_span

  second_tick #(.CYCLES(TICK_CYCLES_P)) u_tick (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .o_tick(tick),
    .o_phase(flash_phase)
  );

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign cfg[i] = '{en: ctrl[CTRL_EN_LSB + i], high: ctrl[CTRL_HIGH_LSB + i], setpoint: setpoint[i],
                      hyst: hyst[i], delay_s: delay_s[i], silence_s: silence_s[i]};
    alarm_channel u_ch (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_tick(tick),
      .i_flash_phase(flash_phase),
      .i_accept(accept),
      .i_display(i_display_value),
      .i_cfg(cfg[i]),
      .o_active(ch_active[i]),
      .o_annunciator(ch_annun[i]),
      .o_state(ch_state[i])
    );
  end

  // Step is an accept only outside the menu and not as part of the menu chord
  assign accept = (menu == MENU_DISPLAY) && i_buttons.step && !i_buttons.up;
  assign menu_store = (menu == MENU_EDIT) && i_buttons.exit && in_span(edit_val, span_min, span_max);
  assign wr_en = i_avs_write && !o_avs_waitrequest;
  assign wr_word = merge(rd_mux, i_avs_writedata, i_avs_byteenable);
  assign wr_value = $signed(wr_word[DISP_W-1:0]);
  assign wr_time_ok = (wr_word[31:TIME_W] == '0) && (wr_word[TIME_W-1:0] <= TIME_MAX);

  always_comb begin
    case (i_avs_address)
      OFS_CTRL: rd_mux = {24'h0, ctrl};
      OFS_SETPOINT0: rd_mux = zx(setpoint[0]);
      OFS_SETPOINT1: rd_mux = zx(setpoint[1]);
      OFS_HYST0: rd_mux = zx(hyst[0]);
      OFS_HYST1: rd_mux = zx(hyst[1]);
      OFS_DELAY0: rd_mux = {20'h0, delay_s[0]};
      OFS_DELAY1: rd_mux = {20'h0, delay_s[1]};
      OFS_SILENCE0: rd_mux = {20'h0, silence_s[0]};
      OFS_SILENCE1: rd_mux = {20'h0, silence_s[1]};
      OFS_ACCESS_CODE: rd_mux = {16'h0, access_code};
      OFS_SPAN_MIN: rd_mux = zx(span_min);
      OFS_SPAN_MAX: rd_mux = zx(span_max);
      OFS_STATUS: rd_mux = {24'h0, menu, ch_state[1], ch_state[0], o_annunciator};
      OFS_DISPLAY: rd_mux = zx(i_display_value);
      default: rd_mux = 32'h0;
    endcase
  end

  // One wait state: every access is answered on the second edge, reads from a registered word
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ctrl <= CTRL_RESET;
      access_code <= CODE_RESET;
      span_min <= SPAN_MIN_RESET;
      span_max <= SPAN_MAX_RESET;
      for (int i = 0; i < NUM_CH; i++) begin
        setpoint[i] <= VALUE_RESET;
        hyst[i] <= VALUE_RESET;
        delay_s[i] <= TIME_RESET;
        silence_s[i] <= TIME_RESET;
      end
    end else begin
      if (menu_store) begin
        setpoint[sel_ch] <= edit_val;
      end
      if (wr_en) begin
        case (i_avs_address)
          OFS_CTRL: ctrl <= wr_word[CTRL_W-1:0];
          OFS_SETPOINT0: if (in_span(wr_value, span_min, span_max)) setpoint[0] <= wr_value;
          OFS_SETPOINT1: if (in_span(wr_value, span_min, span_max)) setpoint[1] <= wr_value;
          OFS_HYST0: hyst[0] <= wr_word[DISP_W-1:0];
          OFS_HYST1: hyst[1] <= wr_word[DISP_W-1:0];
          OFS_DELAY0: if (wr_time_ok) delay_s[0] <= wr_word[TIME_W-1:0];
          OFS_DELAY1: if (wr_time_ok) delay_s[1] <= wr_word[TIME_W-1:0];
          OFS_SILENCE0: if (wr_time_ok) silence_s[0] <= wr_word[TIME_W-1:0];
          OFS_SILENCE1: if (wr_time_ok) silence_s[1] <= wr_word[TIME_W-1:0];
          OFS_ACCESS_CODE: access_code <= wr_word[CODE_W-1:0];
          OFS_SPAN_MIN: span_min <= $signed(wr_word[DISP_W-1:0]);
          OFS_SPAN_MAX: span_max <= $signed(wr_word[DISP_W-1:0]);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      menu <= MENU_DISPLAY;
      digit <= 2'h0;
      sel_ch <= 1'b0;
      edit_val <= VALUE_RESET;
      code_entry <= CODE_RESET;
    end else begin
      case (menu)
        MENU_DISPLAY: begin
          if (ctrl[CTRL_ACCESS_BIT] && i_buttons.step && i_buttons.up) begin
            digit <= 2'h0;
            sel_ch <= 1'b0;
            code_entry <= CODE_RESET;
            menu <= (access_code == CODE_OPEN) ? MENU_SELECT : MENU_CODE;
          end
        end
        MENU_CODE: begin
          if (i_buttons.exit) begin
            menu <= (code_entry == access_code) ? MENU_SELECT : MENU_DISPLAY;
          end else if (i_buttons.step) begin
            digit <= digit + 2'h1;
          end else if (i_buttons.up || i_buttons.down) begin
            code_entry[{digit, 2'b00} +: 4] <= bcd_step(code_entry[{digit, 2'b00} +: 4], i_buttons.up);
          end
        end
        MENU_SELECT: begin
          if (i_buttons.exit) begin
            menu <= MENU_DISPLAY;
          end else if (i_buttons.step) begin
            edit_val <= setpoint[sel_ch];
            digit <= 2'h0;
            menu <= MENU_EDIT;
          end else if (i_buttons.up || i_buttons.down) begin
            sel_ch <= ~sel_ch;
          end
        end
        MENU_EDIT: begin
          if (i_buttons.exit) begin
            menu <= MENU_SELECT;
          end else if (i_buttons.step) begin
            digit <= digit + 2'h1;
          end else if (i_buttons.up) begin
            edit_val <= edit_val + $signed(weight(digit));
          end else if (i_buttons.down) begin
            edit_val <= edit_val - $signed(weight(digit));
          end
        end
        default: menu <= MENU_DISPLAY;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      alt_step <= 2'h0;
    end else if (tick) begin
      alt_step <= alt_step + 2'h1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_display_sel <= SHOW_VALUE;
    end else if (menu != MENU_DISPLAY) begin
      o_display_sel <= SHOW_MENU;
    end else if (!ctrl[CTRL_FLASH_BIT]) begin
      o_display_sel <= SHOW_VALUE;
    end else begin
      // Silenced and delaying channels are not active, so they never get a tag slot
      case (alt_step)
        2'h1: o_display_sel <= ch_active[0] ? SHOW_TAG1 : SHOW_VALUE;
        2'h3: o_display_sel <= ch_active[1] ? SHOW_TAG2 : SHOW_VALUE;
        default: o_display_sel <= SHOW_VALUE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_alarm_switch <= CTRL_RESET[CTRL_NC_LSB +: NUM_CH];
      o_annunciator <= '0;
      o_edit_value <= VALUE_RESET;
      o_edit_digit <= 2'h0;
    end else begin
      o_alarm_switch <= ch_active ^ ctrl[CTRL_NC_LSB +: NUM_CH];
      o_annunciator <= ch_annun;
      o_edit_value <= (menu == MENU_CODE) ? DISP_W'(code_entry) : edit_val;
      o_edit_digit <= digit;
    end
  end

  sequence s_quiet_ch0;
    !ctrl[CTRL_EN_LSB] [*3];
  endsequence

  a_idle_polarity: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    s_quiet_ch0 |=> o_alarm_switch[0] == $past(ctrl[CTRL_NC_LSB]))
    else $error("idle output polarity wrong");
  a_span_reject: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    menu == MENU_EDIT && i_buttons.exit && !in_span(edit_val, span_min, span_max) && !wr_en
      |=> setpoint[$past(sel_ch)] == $past(setpoint[sel_ch]))
    else $error("out of span setpoint stored");
  a_tag_needs_out: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_display_sel == SHOW_TAG1 |-> $past(ch_active[0]))
    else $error("tag shown without active output");
  a_access_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    menu == MENU_DISPLAY && !ctrl[CTRL_ACCESS_BIT] |=> menu == MENU_DISPLAY)
    else $error("setpoint menu opened while disabled");
  a_open_code: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    menu == MENU_DISPLAY && ctrl[CTRL_ACCESS_BIT] && i_buttons.step && i_buttons.up && access_code == CODE_OPEN
      |=> menu == MENU_SELECT ##1 o_display_sel == SHOW_MENU)
    else $error("zero code did not grant access");
endmodule : dual_process_alarm_logic

/* File: tb/button_panel.sv */
// Front-panel push button model.
// Assumes the bench calls press() from one thread only.
`timescale 1ns/1ps
module button_panel import alarm_pkg::*; (
  input wire logic i_clk_sys,
  output btn_t o_buttons
);
  initial o_buttons = '0;
  // One pulse per press, so one menu action per call
  task automatic press(input btn_t b);
    @(posedge i_clk_sys);
    o_buttons <= b;
    @(posedge i_clk_sys);
    o_buttons <= '0;
  endtask : press
endmodule : button_panel

/* File: tb/dual_process_alarm_logic_tb_top.sv */
// Bench for the dual alarm logic: Avalon master, button model, scenarios.
// Assumes a short tick so one second is TCK clocks.
`timescale 1ns/1ps
module dual_process_alarm_logic_tb_top;
  import alarm_pkg::*;
  localparam int TCK = 20;
  localparam btn_t STEP = 4'b1000;
  localparam btn_t CHORD = 4'b1100;
  localparam btn_t EXIT = 4'b0001;
  localparam btn_t UP = 4'b0100;
  logic [DISP_W-1:0] edval;
  logic [1:0] eddig;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic [31:0] readdata;
  logic waitreq;
  logic signed [DISP_W-1:0] dval = '0;
  btn_t btn;
  logic [NUM_CH-1:0] sw;
  logic [NUM_CH-1:0] ann;
  disp_sel_t sel;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2 clk_sys = ~clk_sys;
  button_panel button_panel_inst (.i_clk_sys(clk_sys), .o_buttons(btn));
  dual_process_alarm_logic #(.TICK_CYCLES_P(TCK)) dual_process_alarm_logic_inst (
    .i_clk_sys(clk_sys), .i_reset(reset), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
    .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq), .i_display_value(dval),
    .i_buttons(btn), .o_alarm_switch(sw), .o_annunciator(ann), .o_display_sel(sel),
    .o_edit_value(edval), .o_edit_digit(eddig)
  );
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Request held until a rising edge samples waitrequest low; read data taken at that same edge
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk_sys); while (waitreq !== 1'b0);
    rdat = readdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    check(nm, rdat, e);
  endtask : rchk
  task automatic waitc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : waitc
  task automatic wsw(input int ch, input logic v, input int n);
    for (int i = 0; i < n && sw[ch] !== v; i++) @(negedge clk_sys);
    check("switch", {31'h0, sw[ch]}, {31'h0, v});
  endtask : wsw
  task automatic wsel(input disp_sel_t v, input int n);
    for (int i = 0; i < n && sel !== v; i++) @(negedge clk_sys);
    check("sel", {30'h0, sel}, {30'h0, v});
  endtask : wsel
  task automatic disp(input int v);
    @(posedge clk_sys);
    dval <= DISP_W'(v);
  endtask : disp
  task automatic t_reset;
    rchk(OFS_CTRL, 32'h0, "ctrl");
    rchk(OFS_ACCESS_CODE, 32'h0, "code");
    rchk(6'h3c, 32'h0, "unmapped");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_span;
    bus(1'b1, OFS_SETPOINT0, 32'd10126);
    rchk(OFS_SETPOINT0, 32'h0, "sp0 over span");
    bus(1'b1, OFS_SETPOINT0, 32'd9000);
    rchk(OFS_SETPOINT0, 32'd9000, "sp0");
    bus(1'b1, OFS_DELAY0, 32'd3601);
    rchk(OFS_DELAY0, 32'h0, "delay over max");
    bus(1'b1, OFS_HYST0, 32'd200);
    $display("t_span done");
  endtask : t_span
  task automatic t_high;
    disp(8999);
    bus(1'b1, OFS_CTRL, 32'h05);
    waitc(5);
    wsw(0, 1'b0, 0);
    disp(9000);
    wsw(0, 1'b1, 5);
    waitc(2);
    check("ann0", {31'h0, ann[0]}, 32'h1);
    disp(8800);
    waitc(5);
    wsw(0, 1'b1, 0);
    disp(8799);
    wsw(0, 1'b0, 5);
    bus(1'b1, OFS_CTRL, 32'h15);
    wsw(0, 1'b1, 5);
    bus(1'b1, OFS_CTRL, 32'h0);
    rchk(OFS_SETPOINT0, 32'd9000, "sp0 kept");
    $display("t_high done");
  endtask : t_high
  // Delay of 5 s: a lapse must restart it, so no output 70 clocks after re-arming
  task automatic t_delay;
    bus(1'b1, OFS_DELAY0, 32'd5);
    bus(1'b1, OFS_CTRL, 32'h05);
    disp(9000);
    waitc(45);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("state0", {30'h0, rdat[3:2]}, 32'h1);
    disp(0);
    waitc(3);
    disp(9000);
    waitc(70);
    wsw(0, 1'b0, 0);
    wsw(0, 1'b1, 40);
    waitc(2);
    check("ann0", {31'h0, ann[0]}, 32'h1);
    check("sel", {30'h0, sel}, 32'h0);
    $display("t_delay done");
  endtask : t_delay
  task automatic t_silence;
    bus(1'b1, OFS_SILENCE0, 32'd2);
    bus(1'b1, OFS_CTRL, 32'h45);
    wsel(SHOW_TAG1, 90);
    button_panel_inst.press(STEP);
    wsw(0, 1'b0, 5);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("state0", {30'h0, rdat[3:2]}, 32'h3);
    wsw(0, 1'b1, 60);
    disp(0);
    bus(1'b1, OFS_CTRL, 32'h0);
    $display("t_silence done");
  endtask : t_silence
  task automatic t_low;
    bus(1'b1, OFS_SETPOINT1, 32'd100);
    bus(1'b1, OFS_HYST1, 32'd10);
    disp(101);
    bus(1'b1, OFS_CTRL, 32'h02);
    waitc(5);
    wsw(1, 1'b0, 0);
    disp(100);
    wsw(1, 1'b1, 5);
    waitc(2);
    check("ann", {30'h0, ann}, 32'h2);
    disp(110);
    waitc(5);
    wsw(1, 1'b1, 0);
    disp(111);
    wsw(1, 1'b0, 5);
    $display("t_low done");
  endtask : t_low
  task automatic t_menu;
    button_panel_inst.press(CHORD);
    waitc(3);
    check("sel no access", {30'h0, sel}, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h80);
    button_panel_inst.press(CHORD);
    waitc(3);
    check("sel menu", {30'h0, sel}, 32'h3);
    button_panel_inst.press(STEP);
    button_panel_inst.press(UP);
    waitc(3);
    check("edit", {14'h0, edval}, 32'd9001);
    button_panel_inst.press(STEP);
    waitc(3);
    check("digit", {30'h0, eddig}, 32'h1);
    button_panel_inst.press(EXIT);
    rchk(OFS_SETPOINT0, 32'd9001, "sp0 stored");
    bus(1'b1, OFS_SPAN_MAX, 32'd9001);
    button_panel_inst.press(STEP);
    button_panel_inst.press(UP);
    button_panel_inst.press(EXIT);
    rchk(OFS_SETPOINT0, 32'd9001, "sp0 out of span");
    button_panel_inst.press(EXIT);
    waitc(3);
    check("sel left", {30'h0, sel}, 32'h0);
    bus(1'b1, OFS_ACCESS_CODE, 32'h1);
    button_panel_inst.press(CHORD);
    button_panel_inst.press(UP);
    waitc(3);
    check("code", {14'h0, edval}, 32'h1);
    button_panel_inst.press(EXIT);
    waitc(3);
    check("sel code ok", {30'h0, sel}, 32'h3);
    $display("t_menu done");
  endtask : t_menu
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_span();
    t_high();
    t_delay();
    t_silence();
    t_low();
    t_menu();
    stop_test();
  end
endmodule : dual_process_alarm_logic_tb_top
